/* inc/rcp_map.svh */
// register map and timing constants for reset cause and peripheral reset block
// Functional notes
// RULE_01 - read-only 32-bit part identification register holding the part number code
// RULE_02 - cause bit 7 set when core one-shot reset fires
// RULE_03 - cause bit 5 set on core system reset request
// RULE_04 - cause bit 4 set on brownout detector reset
// RULE_05 - cause bit 3 set on low-voltage reset
// RULE_06 - cause bit 2 set on watchdog reset
// RULE_07 - cause bit 1 set on external reset pin low
// RULE_08 - cause bit 0 set on power-on or whole-chip one-shot reset
// RULE_09 - writing one clears a cause flag, zero leaves it
// RULE_10 - core one-shot resets core and flash controller, self-clears after 2 cycles
// RULE_11 - chip one-shot resets core and peripherals, self-clears after 2 cycles
// RULE_12 - chip one-shot acts as power-on reset, reloading flash configuration
// RULE_13 - software unlocks protection before one-shot writes; locked writes ignored
// RULE_14 - set peripheral bit holds its controller in asynchronous reset until cleared
// RULE_15 - bits 27, 23, 20 reset usb, keyboard port, pulse width blocks
// RULE_16 - bits 17, 16 serial ports, 13, 12 sync serial, 9 two-wire
// RULE_17 - bits 5, 4, 3 reset timers 3, 2, 1; others reserved
// RULE_18 - bit 2 resets timer 0, bit 1 resets gpio
// RULE_19 - cause flags survive the resets they record until software clears them
// RULE_20 - reserved bits read zero and ignore writes
`ifndef RCP_MAP_SVH
`define RCP_MAP_SVH
`define RCP_OFS_PART_ID 8'h00
`define RCP_OFS_CAUSE 8'h04
`define RCP_OFS_CORE_CHIP 8'h08
`define RCP_OFS_PERIPH 8'h0c
`define RCP_BIT_CORE_ONESHOT 7
`define RCP_BIT_CORE_REQUEST 5
`define RCP_BIT_BROWNOUT 4
`define RCP_BIT_LOW_VOLTAGE 3
`define RCP_BIT_WATCHDOG 2
`define RCP_BIT_EXT_PIN 1
`define RCP_BIT_POWER_ON 0
`define RCP_CAUSE_MASK 32'h0000_00bf
`define RCP_CTL_MASK 32'h0000_0003
`define RCP_PERIPH_MASK 32'h0893_323e
`define RCP_BIT_CHIP 0
`define RCP_BIT_CORE 1
`define RCP_ONESHOT_CYCLES 2'h2
`define RCP_PERIPH_RESET 32'h0000_0000
`endif

/* inc/rcp_pkg.sv */
// types for reset cause and peripheral reset block
package rcp_pkg;
  typedef struct packed {
    logic por;
    logic ext_pin;
    logic watchdog;
    logic low_voltage;
    logic brownout;
    logic core_request;
  } rcp_cause_s;
  typedef struct packed {
    logic usb_device_block_reset;
    logic keyboard_port_block_reset;
    logic pulse_width_block_reset;
    logic serial_port1_block_reset;
    logic serial_port0_block_reset;
    logic sync_serial1_block_reset;
    logic sync_serial0_block_reset;
    logic two_wire_block_reset;
    logic timer_three_block_reset;
    logic timer_two_block_reset;
    logic timer_one_block_reset;
    logic timer_zero_block_reset;
    logic gpio_block_reset;
  } rcp_periph_s;
endpackage

/* hw/rcp_reset_ctrl.sv */
// reset cause flags, one-shot resets and peripheral reset bank
`timescale 1ns/100ps
`include "rcp_map.svh"
module rcp_reset_ctrl import rcp_pkg::*; #(
  parameter logic [31:0] PART_NUMBER = 32'h0000_0a5a
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic bus_sel,
  input wire logic bus_wr,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata,
  input wire logic prot_unlocked,
  input wire rcp_cause_s cause_evt,
  output logic core_flash_reset,
  output logic chip_reset,
  output rcp_periph_s periph_reset
);
  // PART_NUMBER default is arbitrary
  logic [31:0] cause_r;
  logic [1:0] ctl_r;
  logic core_shot_r;
  logic chip_shot_r;
  logic [1:0] core_cnt_r;
  logic [1:0] chip_cnt_r;
  logic [31:0] periph_r;
  logic wr_cause;
  logic wr_ctl;
  logic wr_periph;
  rcp_cause_s evt_s1_r;
  rcp_cause_s evt_s2_r;
  logic [31:0] evt_bits;

  assign wr_cause = bus_sel && bus_wr && bus_addr == `RCP_OFS_CAUSE;
  assign wr_ctl = bus_sel && bus_wr && bus_addr == `RCP_OFS_CORE_CHIP;
  assign wr_periph = bus_sel && bus_wr && bus_addr == `RCP_OFS_PERIPH;
  // one-shot bits packed in register order, core at bit 1
  assign ctl_r = {core_shot_r, chip_shot_r};

  // cause events come from other domains
  always_ff @(posedge clk_sys) begin
    evt_s1_r <= cause_evt;
    evt_s2_r <= evt_s1_r;
  end

  always_comb begin
    evt_bits = 32'h0000_0000;
    // RULE_03 core request flag
    evt_bits[`RCP_BIT_CORE_REQUEST] = evt_s2_r.core_request;
    // RULE_04 brownout flag
    evt_bits[`RCP_BIT_BROWNOUT] = evt_s2_r.brownout;
    // RULE_05 low voltage flag
    evt_bits[`RCP_BIT_LOW_VOLTAGE] = evt_s2_r.low_voltage;
    // RULE_06 watchdog flag
    evt_bits[`RCP_BIT_WATCHDOG] = evt_s2_r.watchdog;
    // RULE_07 external pin flag
    evt_bits[`RCP_BIT_EXT_PIN] = evt_s2_r.ext_pin;
    // RULE_08 power-on or chip one-shot
    evt_bits[`RCP_BIT_POWER_ON] = evt_s2_r.por || ctl_r[`RCP_BIT_CHIP];
    // RULE_02 core one-shot flag
    evt_bits[`RCP_BIT_CORE_ONESHOT] = ctl_r[`RCP_BIT_CORE];
  end

  // RULE_19 flags not cleared by reset
  // RULE_09 write one clears, set wins
  always_ff @(posedge clk_sys) begin
    if (wr_cause) begin
      cause_r <= ((cause_r & ~bus_wdata) | evt_bits) & `RCP_CAUSE_MASK;
    end else begin
      cause_r <= (cause_r | evt_bits) & `RCP_CAUSE_MASK;
    end
  end

  // RULE_13 locked writes ignored
  // RULE_10 core one-shot self-clears after 2 cycles
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      core_shot_r <= 1'b0;
      core_cnt_r <= 2'h0;
    end else if (wr_ctl && prot_unlocked && bus_wdata[`RCP_BIT_CORE] && !core_shot_r) begin
      core_shot_r <= 1'b1;
      core_cnt_r <= `RCP_ONESHOT_CYCLES;
    end else if (core_cnt_r != 2'h0) begin
      core_cnt_r <= core_cnt_r - 2'h1;
      core_shot_r <= core_cnt_r != 2'h1;
    end
  end

  // RULE_11 chip one-shot self-clears after 2 cycles
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      chip_shot_r <= 1'b0;
      chip_cnt_r <= 2'h0;
    end else if (wr_ctl && prot_unlocked && bus_wdata[`RCP_BIT_CHIP] && !chip_shot_r) begin
      chip_shot_r <= 1'b1;
      chip_cnt_r <= `RCP_ONESHOT_CYCLES;
    end else if (chip_cnt_r != 2'h0) begin
      chip_cnt_r <= chip_cnt_r - 2'h1;
      chip_shot_r <= chip_cnt_r != 2'h1;
    end
  end

  // RULE_12 chip reset drives full reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      core_flash_reset <= 1'b0;
      chip_reset <= 1'b0;
    end else begin
      core_flash_reset <= ctl_r[`RCP_BIT_CORE];
      chip_reset <= ctl_r[`RCP_BIT_CHIP];
    end
  end

  // RULE_20 reserved bits masked
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      periph_r <= `RCP_PERIPH_RESET;
    end else if (wr_periph) begin
      periph_r <= bus_wdata & `RCP_PERIPH_MASK;
    end
  end

  // RULE_14 held until software clears
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      periph_reset <= '0;
    end else begin
      // RULE_15 usb, keyboard, pulse width
      periph_reset.usb_device_block_reset <= periph_r[27];
      periph_reset.keyboard_port_block_reset <= periph_r[23];
      periph_reset.pulse_width_block_reset <= periph_r[20];
      // RULE_16 serial and two-wire
      periph_reset.serial_port1_block_reset <= periph_r[17];
      periph_reset.serial_port0_block_reset <= periph_r[16];
      periph_reset.sync_serial1_block_reset <= periph_r[13];
      periph_reset.sync_serial0_block_reset <= periph_r[12];
      periph_reset.two_wire_block_reset <= periph_r[9];
      // RULE_17 timers 3 to 1
      periph_reset.timer_three_block_reset <= periph_r[5];
      periph_reset.timer_two_block_reset <= periph_r[4];
      periph_reset.timer_one_block_reset <= periph_r[3];
      // RULE_18 timer 0 and gpio
      periph_reset.timer_zero_block_reset <= periph_r[2];
      periph_reset.gpio_block_reset <= periph_r[1];
    end
  end

  // RULE_01 part id read
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_rdata <= 32'h0000_0000;
    end else if (bus_sel && !bus_wr) begin
      unique case (bus_addr)
        `RCP_OFS_PART_ID: bus_rdata <= PART_NUMBER;
        `RCP_OFS_CAUSE: bus_rdata <= cause_r;
        `RCP_OFS_CORE_CHIP: bus_rdata <= {30'h0, ctl_r};
        `RCP_OFS_PERIPH: bus_rdata <= periph_r;
        default: bus_rdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

/* verification/rcp_reset_ctrl_chk.sv */
// assertion checker for the reset control block
`timescale 1ns/100ps
module rcp_reset_ctrl_chk import rcp_pkg::*; #(parameter logic [31:0] PART_NUMBER = 32'h0000_0a5a) (
  input wire logic clk_sys, reset, bus_sel, bus_wr, prot_unlocked, core_flash_reset, chip_reset,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata, bus_rdata,
  input wire rcp_cause_s cause_evt,
  input wire rcp_periph_s periph_reset
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire w_ctl = bus_sel && bus_wr && bus_addr == 8'h08 && prot_unlocked;
  wire w_per = bus_sel && bus_wr && bus_addr == 8'h0c;
  wire rd = bus_sel && !bus_wr;
  function automatic rcp_periph_s f_map(logic [31:0] d);
    return {d[27], d[23], d[20], d[17:16], d[13:12], d[9], d[5:1]};
  endfunction
  sequence s_two(x);
    x ##1 x ##1 !x;
  endsequence
  property p_chip_len; $rose(chip_reset) |-> s_two(chip_reset); endproperty
  property p_core_len; $rose(core_flash_reset) |-> s_two(core_flash_reset); endproperty
  property p_chip_src; $rose(chip_reset) |-> $past(w_ctl && bus_wdata[0]) || $past(w_ctl && bus_wdata[0], 2);
  endproperty
  property p_core_src; $rose(core_flash_reset) |-> $past(w_ctl && bus_wdata[1]) || $past(w_ctl && bus_wdata[1], 2);
  endproperty
  property p_per; w_per ##1 !w_per |=> periph_reset == f_map($past(bus_wdata, 2)); endproperty
  property p_hold; (!w_per) [*3] |-> $stable(periph_reset); endproperty
  property p_pid; rd && bus_addr == 8'h00 |=> ##[0:1] bus_rdata == PART_NUMBER; endproperty
  property p_rsv; rd && !(bus_addr inside {8'h00, 8'h04, 8'h08, 8'h0c}) |=> ##[0:1] bus_rdata == '0; endproperty
  a_chip_len: assert property (p_chip_len) else $error("chip reset width");
  a_core_len: assert property (p_core_len) else $error("core reset width");
  a_chip_src: assert property (p_chip_src) else $error("chip reset cause");
  a_core_src: assert property (p_core_src) else $error("core reset cause");
  a_per: assert property (p_per) else $error("periph map");
  a_hold: assert property (p_hold) else $error("periph hold");
  a_pid: assert property (p_pid) else $error("part id");
  a_rsv: assert property (p_rsv) else $error("unmapped read");
endmodule
bind rcp_reset_ctrl rcp_reset_ctrl_chk #(.PART_NUMBER(PART_NUMBER)) u_chk (
  .clk_sys(clk_sys),
  .reset(reset),
  .bus_sel(bus_sel),
  .bus_wr(bus_wr),
  .prot_unlocked(prot_unlocked),
  .core_flash_reset(core_flash_reset),
  .chip_reset(chip_reset),
  .bus_addr(bus_addr),
  .bus_wdata(bus_wdata),
  .bus_rdata(bus_rdata),
  .cause_evt(cause_evt),
  .periph_reset(periph_reset)
);

/* verification/rcp_periph_model.sv */
// peripheral controllers held in reset by the block
`timescale 1ns/100ps
module rcp_periph_model import rcp_pkg::*; (
  input wire logic clk_sys,
  input wire rcp_periph_s periph_reset,
  output wire rcp_periph_s alive
);
  for (genvar i = 0; i < 13; i++) begin : g_ctl
    logic up_r;
    always_ff @(posedge clk_sys or posedge periph_reset[i]) begin
      if (periph_reset[i]) begin
        up_r <= 1'b0;
      end else begin
        up_r <= 1'b1;
      end
    end
    assign alive[i] = up_r;
  end
endmodule

/* verification/rcp_reset_ctrl_tb.sv */
// testbench for the reset control block
`timescale 1ns/100ps
module rcp_reset_ctrl_tb;
  import rcp_pkg::*;
  logic clk_sys = 0, reset = 1, bus_sel = 0, bus_wr = 0, prot_unlocked = 0;
  logic [7:0] bus_addr = 0;
  logic [31:0] bus_wdata = 0, bus_rdata, d, v;
  rcp_cause_s cause_evt = '0;
  logic core_flash_reset, chip_reset;
  rcp_periph_s periph_reset, alive;
  int mismatches = 0, n_compared = 0;
  int hi_core = 0, hi_chip = 0, b_core, b_chip;
  always #2.5 clk_sys = ~clk_sys;
  rcp_reset_ctrl dut (
    .clk_sys(clk_sys),
    .reset(reset),
    .bus_sel(bus_sel),
    .bus_wr(bus_wr),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata),
    .prot_unlocked(prot_unlocked),
    .cause_evt(cause_evt),
    .core_flash_reset(core_flash_reset),
    .chip_reset(chip_reset),
    .periph_reset(periph_reset)
  );
  rcp_periph_model u_pm (
    .clk_sys(clk_sys),
    .periph_reset(periph_reset),
    .alive(alive)
  );
  // count cycles each one-shot output stands high, sampled away from the launch edge
  always @(negedge clk_sys) begin
    hi_core += int'(core_flash_reset === 1'b1);
    hi_chip += int'(chip_reset === 1'b1);
  end
  function automatic logic [12:0] pe(logic [31:0] x);
    return {x[27], x[23], x[20], x[17:16], x[13:12], x[9], x[5:1]};
  endfunction
  task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [31:0] wd);
    @(negedge clk_sys);
    {bus_sel, bus_wr, bus_addr, bus_wdata} = {1'b1, w, a, wd};
    @(negedge clk_sys);
    bus_sel = 0;
    @(negedge clk_sys);
    v = bus_rdata;
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h971f));
    repeat (10) @(negedge clk_sys);
    reset = 0;
    acc(0, 8'h00, 0);
    chk("part id", v, 32'h0000_0a5a);
    acc(0, 8'h10, 0);
    chk("unmapped", v, 0);
    acc(1, 8'h04, 32'hff);
    $display("id test end");
    for (int k = 0; k < 6; k++) begin
      cause_evt = 6'(1 << k);
      repeat (3) @(negedge clk_sys);
      cause_evt = '0;
      repeat (4) @(negedge clk_sys);
      reset = 1;
      @(negedge clk_sys);
      reset = 0;
      acc(1, 8'h04, 0);
      acc(0, 8'h04, 0);
      chk("cause set", v, 32'(1 << (5 - k)));
      acc(1, 8'h04, 32'h40 | 32'(1 << (5 - k)));
      acc(0, 8'h04, 0);
      chk("cause clear", v, 0);
    end
    $display("cause test end");
    b_core = hi_core;
    b_chip = hi_chip;
    acc(1, 8'h08, 3);
    acc(0, 8'h04, 0);
    chk("locked", v, 0);
    chk("locked pulses", hi_core + hi_chip - b_core - b_chip, 0);
    prot_unlocked = 1;
    for (int k = 0; k < 2; k++) begin
      b_core = hi_core;
      b_chip = hi_chip;
      acc(1, 8'h08, 32'(1 << k));
      acc(0, 8'h04, 0);
      chk("oneshot cause", v, k ? 32'h80 : 32'h1);
      acc(0, 8'h08, 0);
      chk("oneshot clear", v, 0);
      chk("core pulse", hi_core - b_core, k ? 2 : 0);
      chk("chip pulse", hi_chip - b_chip, k ? 0 : 2);
      acc(1, 8'h04, 32'hff);
    end
    $display("oneshot test end");
    for (int i = 0; i < 24; i++) begin
      d = i < 2 ? {32{i[0]}} : $urandom;
      acc(1, 8'h0c, d);
      acc(0, 8'h0c, 0);
      chk("periph reg", v, d & 32'h0893_323e);
      chk("periph held", {19'h0, alive}, {19'h0, ~pe(d)});
    end
    $display("periph test end");
    results();
  end
  initial begin
    #100000;
    mismatches++;
    results();
  end
endmodule
